// ===== scmfw_regs.vh
`ifndef SCMFW_REGS_VH
`define SCMFW_REGS_VH

// Register byte offsets
`define SCMFW_MODE_OFF 12'h000
`define SCMFW_IDLE_OFF 12'h004

// Mode control fields
`define SCMFW_DIV_HI 7
`define SCMFW_DIV_LO 5
`define SCMFW_FAST_BIT 4
`define SCMFW_LRDY_BIT 3
`define SCMFW_HRDY_BIT 2
`define SCMFW_IDLE_BIT 1
`define SCMFW_HIGH_BIT 0

// Idle/reset flags fields
`define SCMFW_KEEP_BIT 7
`define SCMFW_FLAGS_HI 2

// Reset values
`define SCMFW_DIV_RST 3'h0
`define SCMFW_FAST_RST 1'h0
`define SCMFW_IDLE_RST 1'h1
`define SCMFW_HIGH_RST 1'h1
`define SCMFW_KEEP_RST 1'h0
`define SCMFW_FLAGS_RST 3'h0

// Divider codes
`define SCMFW_CKS_LOW1 3'h1
`define SCMFW_CKS_D64 3'h2
`define SCMFW_CKS_D32 3'h3
`define SCMFW_CKS_D16 3'h4
`define SCMFW_CKS_D8 3'h5
`define SCMFW_CKS_D4 3'h6
`define SCMFW_CKS_D2 3'h7

// Divider masks (ratio minus one)
`define SCMFW_M64 6'h3F
`define SCMFW_M32 6'h1F
`define SCMFW_M16 6'h0F
`define SCMFW_M8 6'h07
`define SCMFW_M4 6'h03
`define SCMFW_M2 6'h01

// Oscillator settle counts
`define SCMFW_XTAL_CYC 128
`define SCMFW_RC_CYC 16

`endif

// ===== scmfw_clock_mode.v
// Function
// - divider field picks low clock (000/001) or high clock /64 down to /2.
// - divider field ignored while full high clock selected.
// - high select bit one gives undivided high clock as system clock.
// - moving to low clock stops the high oscillator and its derived clocks.
// - running from low clock also stops high/16 and high/64 peripheral ticks.
// - fast wake bit with crystal runs system from substitute clock after wake-up.
// - low oscillator ready flag reads zero until low oscillator stable.
// - high ready flag cleared at power-on, low in sleep, idle-off, low-run.
// - high ready rises after 128 crystal or 16 RC oscillator cycles.
// - halt enters idle if idle select set, otherwise sleep.
// - idle with clock keep runs system clock; without it system clock and high oscillator stop, time-base keeps running.
// - unimplemented bits 6 to 3 of second register read zero.
// - three reset-cause flags, read/write, zero after reset, set externally.
// - fast wake only applies when waking from sleep or idle-off.
// - crystal fast wake: 1-2 substitute cycles, substitute until ready, then crystal.
// - RC oscillators wake in 16 or 1-2 cycles; fast wake bit ignored.
// - substitute and time-base clocks come from configured low oscillator.
// - entering sleep or idle clears watchdog, sets power-down, clears time-out.
`timescale 1ns/100ps
`include "scmfw_regs.vh"

module scmfw_clock_mode #(
  parameter XTAL_CYC = `SCMFW_XTAL_CYC,
  parameter RC_CYC = `SCMFW_RC_CYC
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire [31:0] prdata,
  output wire pslverr,
  input wire cfg_high_is_crystal,
  input wire cfg_low_is_crystal,
  input wire low_rc_tick,
  input wire low_crystal_tick,
  input wire low_osc_stable,
  input wire halt_exec,
  input wire wake_event,
  input wire [2:0] reset_cause_set,
  output wire high_osc_enable,
  output wire sysclk_tick,
  output wire cpu_run,
  output wire substitute_tick,
  output wire timebase_tick,
  output wire high_div16_tick,
  output wire high_div64_tick,
  output wire watchdog_clear,
  output wire power_down_set,
  output wire watchdog_expired_clear,
  output wire [2:0] power_state
);

  localparam ST_RUN = 3'h0;
  localparam ST_SLEEP = 3'h1;
  localparam ST_IDLE_OFF = 3'h2;
  localparam ST_IDLE_ON = 3'h3;
  localparam ST_WAKE = 3'h4;
  localparam ST_FAST = 3'h5;

  localparam SRC_FULL = 2'h0;
  localparam SRC_DIV = 2'h1;
  localparam SRC_LOW = 2'h2;
  localparam SRC_SUB = 2'h3;

  reg [2:0] div_sel_ff;
  reg fast_en_ff;
  reg idle_sel_ff;
  reg high_sel_ff;
  reg keep_ff;
  reg [2:0] flags_ff;
  reg [2:0] nxt_flags;
  reg low_rdy_ff;
  reg high_rdy_ff;
  reg [7:0] osc_cnt_ff;
  reg [5:0] div_cnt_ff;
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [1:0] src_ff;
  reg [2:0] src_div_ff;
  reg [1:0] want_src;
  reg fast_wake_ff;
  reg pready_ff;
  reg pslverr_ff;
  reg [31:0] prdata_ff;
  reg [31:0] rdata;
  reg [5:0] cur_mask;
  reg cur_tick;
  reg halt_pulse_ff;

  wire low_tick;
  wire wr_en;
  wire mode_hit;
  wire idle_hit;
  wire settle_done;
  wire need_high;
  wire [7:0] settle_cyc;
  wire halted;
  wire high_live;

  assign low_tick = cfg_low_is_crystal ? low_crystal_tick : low_rc_tick;
  assign mode_hit = (paddr == `SCMFW_MODE_OFF);
  assign idle_hit = (paddr == `SCMFW_IDLE_OFF);
  assign wr_en = psel & penable & pready_ff & pwrite;
  assign halted = (state_ff == ST_SLEEP) | (state_ff == ST_IDLE_OFF) | (state_ff == ST_IDLE_ON);

  // Target source from software selection
  always @* begin
    if (high_sel_ff) begin
      want_src = SRC_FULL;
    end else if (div_sel_ff <= `SCMFW_CKS_LOW1) begin
      want_src = SRC_LOW;
    end else begin
      want_src = SRC_DIV;
    end
  end

  // High oscillator needed unless on low clock or stopped
  assign need_high = ((state_ff == ST_RUN) & ((src_ff != SRC_LOW) | (want_src != SRC_LOW)))
    | ((state_ff == ST_IDLE_ON) & (src_ff != SRC_LOW))
    | (state_ff == ST_WAKE) | (state_ff == ST_FAST);
  assign high_osc_enable = need_high;
  assign settle_cyc = cfg_high_is_crystal ? XTAL_CYC[7:0] : RC_CYC[7:0];
  assign settle_done = (osc_cnt_ff == settle_cyc - 8'h01);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_cnt_ff <= 8'h00;
      high_rdy_ff <= 1'b0;
    end else if (!need_high) begin
      osc_cnt_ff <= 8'h00;
      high_rdy_ff <= 1'b0;
    end else if (!high_rdy_ff) begin
      osc_cnt_ff <= osc_cnt_ff + 8'h01;
      high_rdy_ff <= settle_done;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_rdy_ff <= 1'b0;
    end else begin
      low_rdy_ff <= low_osc_stable;
    end
  end

  // Free-running high clock divider
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_ff <= 6'h00;
    end else if (high_rdy_ff) begin
      div_cnt_ff <= div_cnt_ff + 6'h01;
    end else begin
      div_cnt_ff <= 6'h00;
    end
  end

  always @* begin
    case (src_div_ff)
      `SCMFW_CKS_D64: cur_mask = `SCMFW_M64;
      `SCMFW_CKS_D32: cur_mask = `SCMFW_M32;
      `SCMFW_CKS_D16: cur_mask = `SCMFW_M16;
      `SCMFW_CKS_D8: cur_mask = `SCMFW_M8;
      `SCMFW_CKS_D4: cur_mask = `SCMFW_M4;
      default: cur_mask = `SCMFW_M2;
    endcase
  end

  always @* begin
    case (src_ff)
      SRC_FULL: cur_tick = high_rdy_ff;
      SRC_DIV: cur_tick = high_rdy_ff & ((div_cnt_ff & cur_mask) == cur_mask);
      default: cur_tick = low_tick;
    endcase
  end

  // Source switches at the end of a current period, or at once from substitute or while high clock not ready
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_ff <= SRC_FULL;
      src_div_ff <= `SCMFW_CKS_D2;
    end else if (state_ff == ST_FAST) begin
      src_ff <= SRC_SUB;
    end else if (state_ff == ST_RUN && (src_ff == SRC_SUB || cur_tick || !high_rdy_ff)) begin
      src_ff <= want_src;
      src_div_ff <= div_sel_ff;
    end
  end

  assign sysclk_tick = (state_ff == ST_FAST) ? low_tick
    : cur_tick & ((state_ff == ST_RUN) | (state_ff == ST_IDLE_ON));
  assign cpu_run = (state_ff == ST_RUN) | (state_ff == ST_FAST);
  assign substitute_tick = low_tick;
  assign timebase_tick = low_tick & (state_ff != ST_SLEEP);
  // Derived ticks die with the oscillator, not a cycle later with its ready flag
  assign high_live = need_high & high_rdy_ff;
  assign high_div16_tick = high_live & ((div_cnt_ff & `SCMFW_M16) == `SCMFW_M16);
  assign high_div64_tick = high_live & ((div_cnt_ff & `SCMFW_M64) == `SCMFW_M64);

  // Power state machine
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        if (halt_exec) begin
          if (!idle_sel_ff) begin
            nxt_state = ST_SLEEP;
          end else if (keep_ff) begin
            nxt_state = ST_IDLE_ON;
          end else begin
            nxt_state = ST_IDLE_OFF;
          end
        end
      end
      ST_SLEEP, ST_IDLE_OFF: begin
        if (wake_event) begin
          nxt_state = (src_ff == SRC_LOW) ? ST_RUN : ST_WAKE;
        end
      end
      ST_IDLE_ON: begin
        if (wake_event) begin
          nxt_state = ST_RUN;
        end
      end
      ST_WAKE: begin
        if (fast_wake_ff && low_tick) begin
          nxt_state = ST_FAST;
        end else if (high_rdy_ff) begin
          nxt_state = ST_RUN;
        end
      end
      ST_FAST: begin
        if (high_rdy_ff) begin
          nxt_state = ST_RUN;
        end
      end
      default: nxt_state = ST_RUN;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_RUN;
      fast_wake_ff <= 1'b0;
      halt_pulse_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      halt_pulse_ff <= (state_ff == ST_RUN) & halt_exec;
      if ((state_ff == ST_SLEEP || state_ff == ST_IDLE_OFF) && wake_event) begin
        fast_wake_ff <= fast_en_ff & cfg_high_is_crystal;
      end else if (state_ff != ST_WAKE) begin
        fast_wake_ff <= 1'b0;
      end
    end
  end

  assign watchdog_clear = halt_pulse_ff;
  assign power_down_set = halt_pulse_ff;
  assign watchdog_expired_clear = halt_pulse_ff;
  assign power_state = state_ff;

  // Register writes; hardware set of reset flags wins over a clear
  always @* begin
    nxt_flags = flags_ff;
    if (wr_en && idle_hit) begin
      nxt_flags = pwdata[`SCMFW_FLAGS_HI:0];
    end
    nxt_flags = nxt_flags | reset_cause_set;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_sel_ff <= `SCMFW_DIV_RST;
      fast_en_ff <= `SCMFW_FAST_RST;
      idle_sel_ff <= `SCMFW_IDLE_RST;
      high_sel_ff <= `SCMFW_HIGH_RST;
      keep_ff <= `SCMFW_KEEP_RST;
      flags_ff <= `SCMFW_FLAGS_RST;
    end else begin
      flags_ff <= nxt_flags;
      if (wr_en && mode_hit) begin
        div_sel_ff <= pwdata[`SCMFW_DIV_HI:`SCMFW_DIV_LO];
        fast_en_ff <= pwdata[`SCMFW_FAST_BIT];
        idle_sel_ff <= pwdata[`SCMFW_IDLE_BIT];
        high_sel_ff <= pwdata[`SCMFW_HIGH_BIT];
      end
      if (wr_en && idle_hit) begin
        keep_ff <= pwdata[`SCMFW_KEEP_BIT];
      end
    end
  end

  always @* begin
    rdata = 32'h00000000;
    if (mode_hit) begin
      rdata[`SCMFW_DIV_HI:`SCMFW_DIV_LO] = div_sel_ff;
      rdata[`SCMFW_FAST_BIT] = fast_en_ff;
      rdata[`SCMFW_LRDY_BIT] = low_rdy_ff;
      rdata[`SCMFW_HRDY_BIT] = high_rdy_ff;
      rdata[`SCMFW_IDLE_BIT] = idle_sel_ff;
      rdata[`SCMFW_HIGH_BIT] = high_sel_ff;
    end else if (idle_hit) begin
      rdata[`SCMFW_KEEP_BIT] = keep_ff;
      rdata[`SCMFW_FLAGS_HI:0] = flags_ff;
    end
  end

  // APB slave: one wait state, answer captured into flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else if (psel && penable && !pready_ff) begin
      pready_ff <= 1'b1;
      pslverr_ff <= ~(mode_hit | idle_hit);
      prdata_ff <= pwrite ? 32'h00000000 : rdata;
    end else begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign prdata = prdata_ff;

endmodule

// ===== scmfw_monitor.sv
`timescale 1ns/100ps
module scmfw_monitor (
  input wire pclk,
  input wire presetn,
  input wire halt_exec,
  input wire wake_event,
  input wire cfg_low_is_crystal,
  input wire low_rc_tick,
  input wire low_crystal_tick,
  input wire high_osc_enable,
  input wire sysclk_tick,
  input wire cpu_run,
  input wire substitute_tick,
  input wire timebase_tick,
  input wire high_div16_tick,
  input wire high_div64_tick,
  input wire watchdog_clear,
  input wire power_down_set,
  input wire watchdog_expired_clear,
  input wire [2:0] power_state
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_halt_pulses: assert property (halt_exec && power_state == 3'h0 |-> ##[1:2]
    (watchdog_clear && power_down_set && watchdog_expired_clear)) else $error("halt pulses");
  a_cpu_halted: assert property (power_state inside {3'h1, 3'h2, 3'h3} |-> !cpu_run)
    else $error("cpu runs");
  a_sys_stopped: assert property (power_state inside {3'h1, 3'h2} |->
    !sysclk_tick && !high_osc_enable) else $error("clock runs");
  a_div_osc: assert property (high_div16_tick || high_div64_tick |-> high_osc_enable)
    else $error("div tick");
  a_sub_source: assert property (substitute_tick ==
    (cfg_low_is_crystal ? low_crystal_tick : low_rc_tick)) else $error("sub source");
  a_tb_sleep: assert property (timebase_tick ==
    (substitute_tick && power_state != 3'h1)) else $error("timebase");
  a_idle_wake: assert property (power_state == 3'h3 && wake_event |=>
    power_state == 3'h0) else $error("idle wake");
  a_fast_sub: assert property (power_state == 3'h5 |->
    sysclk_tick == substitute_tick) else $error("fast clock");
endmodule
bind scmfw_clock_mode scmfw_monitor u_mon (
  .pclk(pclk),
  .presetn(presetn),
  .halt_exec(halt_exec),
  .wake_event(wake_event),
  .cfg_low_is_crystal(cfg_low_is_crystal),
  .low_rc_tick(low_rc_tick),
  .low_crystal_tick(low_crystal_tick),
  .high_osc_enable(high_osc_enable),
  .sysclk_tick(sysclk_tick),
  .cpu_run(cpu_run),
  .substitute_tick(substitute_tick),
  .timebase_tick(timebase_tick),
  .high_div16_tick(high_div16_tick),
  .high_div64_tick(high_div64_tick),
  .watchdog_clear(watchdog_clear),
  .power_down_set(power_down_set),
  .watchdog_expired_clear(watchdog_expired_clear),
  .power_state(power_state)
);

// ===== tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic pready, pslverr, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic cfg_high_is_crystal = 1'h1, cfg_low_is_crystal = 1'h0;
  logic low_rc_tick = 1'h0, low_crystal_tick = 1'h0;
  logic low_osc_stable = 1'h0, halt_exec = 1'h0, wake_event = 1'h0;
  logic [2:0] reset_cause_set = 3'h0, power_state;
  logic high_osc_enable, sysclk_tick, cpu_run, substitute_tick, timebase_tick;
  logic high_div16_tick, high_div64_tick, watchdog_clear, power_down_set;
  logic watchdog_expired_clear;
  logic [3:0] cnt = 4'h0;
  logic [7:0] tm [5] = '{8'h01, 8'h03, 8'h03, 8'h11, 8'h11};
  logic [2:0] ts [5] = '{3'h1, 3'h2, 3'h3, 3'h1, 3'h1};
  integer errors = 0, num_checks = 0, n, f, i;
  scmfw_clock_mode #(.XTAL_CYC(16), .RC_CYC(4)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .cfg_high_is_crystal(cfg_high_is_crystal), .cfg_low_is_crystal(cfg_low_is_crystal),
    .low_rc_tick(low_rc_tick), .low_crystal_tick(low_crystal_tick),
    .low_osc_stable(low_osc_stable), .halt_exec(halt_exec), .wake_event(wake_event),
    .reset_cause_set(reset_cause_set), .high_osc_enable(high_osc_enable),
    .sysclk_tick(sysclk_tick), .cpu_run(cpu_run), .substitute_tick(substitute_tick),
    .timebase_tick(timebase_tick), .high_div16_tick(high_div16_tick),
    .high_div64_tick(high_div64_tick), .watchdog_clear(watchdog_clear),
    .power_down_set(power_down_set), .watchdog_expired_clear(watchdog_expired_clear),
    .power_state(power_state)
  );
  always #5 pclk = ~pclk;
  // Low oscillators: RC every 4, crystal every 8 cycles
  always @(posedge pclk) begin
    cnt <= cnt + 4'h1;
    low_rc_tick <= cnt[1:0] == 2'h3;
    low_crystal_tick <= cnt[2:0] == 3'h7;
  end
  task results;
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      $display("[ERR] %s exp %h got %h", nm, e, s);
      errors++;
    end
  endtask
  task cyc(input integer c);
    repeat (c) @(posedge pclk);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer k;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    if (pready !== 1'h1) begin
      errors++;
      results;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task t_reset;
    apb(1'h0, 12'h000, 32'h0);
    chk("mode_rst", 32'h03, rd);
    apb(1'h0, 12'h004, 32'h0);
    chk("ctrl_rst", 32'h00, rd);
    cyc(20);
    low_osc_stable <= 1'h1;
    cyc(3);
    apb(1'h1, 12'h000, 32'hE3);
    apb(1'h0, 12'h000, 32'h0);
    chk("mode_rdy", 32'hEF, rd);
  endtask
  task t_div;
    for (i = 0; i < 8; i++) begin
      apb(1'h1, 12'h000, i == 0 ? 32'h43 : {i[2:0], 5'h02});
      cyc(70);
      n = 0;
      f = 0;
      repeat (128) begin
        @(posedge pclk);
        n += sysclk_tick;
        f += high_div16_tick;
      end
      chk("ticks", i == 0 ? 128 : i == 1 ? 32 : 1 << (i - 1), n);
      if (i == 1) begin
        chk("div16", 32'h0, f);
        chk("hosc", 32'h0, high_osc_enable);
      end
    end
    apb(1'h1, 12'h000, 32'h02);
    cyc(70);
    n = 0;
    repeat (128) begin
      @(posedge pclk);
      n += sysclk_tick;
    end
    chk("low000", 32, n);
    chk("hosc0", 32'h0, high_osc_enable);
    apb(1'h1, 12'h000, 32'h03);
  endtask
  task t_halt;
    cfg_low_is_crystal <= 1'h1;
    for (i = 0; i < 5; i++) begin
      cfg_high_is_crystal <= i < 4;
      apb(1'h1, 12'h004, i == 2 ? 32'h80 : 32'h00);
      apb(1'h1, 12'h000, tm[i]);
      cyc(30);
      halt_exec <= 1'h1;
      @(posedge pclk);
      halt_exec <= 1'h0;
      cyc(3);
      chk("state", ts[i], power_state);
      n = 0;
      repeat (4) begin
        @(posedge pclk);
        n |= sysclk_tick;
      end
      chk("idle_clk", i == 2, n);
      wake_event <= 1'h1;
      @(posedge pclk);
      wake_event <= 1'h0;
      f = 0;
      n = 0;
      while (power_state !== 3'h0 && n < 100) begin
        @(posedge pclk);
        n++;
        if (power_state === 3'h5) f = 1;
      end
      if (power_state !== 3'h0) begin
        errors++;
        results;
      end
      chk("woke", 32'h0, power_state);
      chk("fast", i == 3, f);
    end
    cfg_high_is_crystal <= 1'h1;
  endtask
  task t_flags;
    reset_cause_set <= 3'h5;
    @(posedge pclk);
    reset_cause_set <= 3'h0;
    apb(1'h0, 12'h004, 32'h0);
    chk("cause", 32'h05, rd);
    apb(1'h1, 12'h004, 32'hFA);
    apb(1'h0, 12'h004, 32'h0);
    chk("ctrl_rw", 32'h82, rd);
    apb(1'h0, 12'h008, 32'h0);
    chk("bad_err", 32'h1, er);
    chk("bad_data", 32'h0, rd);
  endtask
  initial begin
    cyc(20);
    presetn <= 1'h1;
    t_reset;
    t_div;
    t_halt;
    t_flags;
    results;
  end
endmodule
